// *** pbm_pkg.sv ***
// Package for the basic mode control and status register pair.
// Assumes a 25 MHz core clock and a management clock that the core samples.
package pbm_pkg;
   // Register addresses on the serial management interface
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_STAT = 5'h01;
   // Control register field positions
   localparam int CTRL_SRST = 15;
   localparam int CTRL_LOOP = 14;
   localparam int CTRL_PWDN = 11;
   localparam int CTRL_ISO = 10;
   // Fixed control fields: speed 100 Mbps, no auto-negotiation
   localparam logic [1:0] CTRL_SPD_AN = 2'h2;
   localparam logic [9:0] CTRL_RSV_VAL = 10'h100;
   // Status register field positions
   localparam int STAT_PRE_SUP = 6;
   localparam int STAT_AN_DONE = 5;
   localparam int STAT_FAULT = 4;
   localparam int STAT_LINK = 2;
   localparam int STAT_JABBER = 1;
   localparam int STAT_EXT_CAP = 0;
   // Status bits that always read one
   localparam logic [15:0] STAT_FIXED = 16'h0061;
   // Management frame layout
   localparam logic [5:0] PRE_BITS = 6'h20;
   localparam logic [4:0] HDR_LAST = 5'h0B;
   localparam logic [4:0] DATA_LAST = 5'h0F;
   localparam logic [1:0] OP_RD = 2'h2;
   localparam logic [1:0] OP_WR = 2'h1;
   localparam logic [1:0] TA_WR = 2'h2;
   // Soft reset duration, rounded up to whole core cycles
   localparam int CLK_NS = 40;
   localparam int SRST_NS = 640;
   localparam int SRST_CYC = (SRST_NS + CLK_NS - 1) / CLK_NS;
   // Frame decoder states, one-hot
   typedef enum logic [4:0]
   {
      S_IDLE = 5'b00001,
      S_ST = 5'b00010,
      S_HDR = 5'b00100,
      S_TA = 5'b01000,
      S_DATA = 5'b10000
   } pbm_state_e;
endpackage

// *** pbm_regs.sv ***
// Basic mode control/status registers with their management frame slave.
// Assumes MAC-side and PCS-side signals are on core_clk; pins are not.
`timescale 1ns/100ps

module pbm_regs
   import pbm_pkg::*;
#(
   parameter int MII_W = 4
)
(
   // Clock and synchronous reset
   input wire logic core_clk,
   input wire logic rst,
   // Serial management pins
   input wire logic mdc,
   input wire logic mdio_i,
   output logic mdio_o,
   output logic mdio_oe,
   // Strap and power-down pins
   input wire logic [3:0] phy_addr_strap,
   input wire logic irq_powerdown_pin_n,
   // PCS status
   input wire logic link_ok_i,
   input wire logic remote_fault_i,
   input wire logic jabber_i,
   // MAC side
   input wire logic [MII_W-1:0] mii_txd,
   input wire logic mii_tx_en,
   output logic [MII_W-1:0] mii_rxd,
   output logic mii_rx_dv,
   output logic mii_rxd_oe,
   // PCS side
   output logic [MII_W-1:0] pcs_txd,
   output logic pcs_tx_en,
   input wire logic [MII_W-1:0] pcs_rxd,
   input wire logic pcs_rx_dv,
   // Block controls
   output logic pcs_reset,
   output logic power_down,
   output logic link_up
);
   // Synchronisers; first stages feed only second stages
   logic mdc_s1_q, mdc_s2_q, mdc_s3_q;
   logic mdio_s1_q, mdio_s2_q;
   logic pin_s1_q, pin_s2_q;
   logic [3:0] strap_s1_q, strap_s2_q;
   // Frame decoder state
   pbm_state_e state_q;
   logic [4:0] cnt_q;
   logic [5:0] ones_q;
   logic pre_ok_q;
   logic [11:0] sh_q;
   logic [15:0] wsh_q;
   logic op_rd_q, match_q;
   logic [4:0] reg_q;
   logic [4:0] addr_q;
   logic strap_pend_q;
   // Read shifter
   logic [15:0] rsh_q;
   // Control fields
   logic srst_q, loop_q, pwdn_q, iso_q;
   logic [4:0] srst_cnt_q;
   // Latched status fields
   logic st_fault_q, st_link_q, st_jabber_q;
   // Decode helpers
   logic rise, bit_in, pin_on, wr_commit, rd_snap, rd_clr, link_now;
   logic [11:0] hdr_next;
   logic [15:0] wdata, ctrl_rd, stat_rd;

   // Pin synchronisers, no reset needed on pure sampling flops
   always_ff @(posedge core_clk)
   begin
      mdc_s1_q <= mdc;
      mdc_s2_q <= mdc_s1_q;
      mdc_s3_q <= mdc_s2_q;
      mdio_s1_q <= mdio_i;
      mdio_s2_q <= mdio_s1_q;
      pin_s1_q <= irq_powerdown_pin_n;
      pin_s2_q <= pin_s1_q;
      strap_s1_q <= phy_addr_strap;
      strap_s2_q <= strap_s1_q;
   end

   // Strap captured once after reset release, soft reset leaves it
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         addr_q <= 5'h00;
         strap_pend_q <= 1'b1;
      end
      else if (strap_pend_q)
      begin
         addr_q <= {1'b0, strap_s2_q};
         strap_pend_q <= 1'b0;
      end
   end

   // Management clock rising edge and the bit it samples
   assign rise = mdc_s2_q & ~mdc_s3_q;
   assign bit_in = mdio_s2_q;
   assign pin_on = ~pin_s2_q;
   assign hdr_next = {sh_q[10:0], bit_in};
   assign wdata = {wsh_q[14:0], bit_in};
   assign wr_commit = rise && state_q == S_DATA && cnt_q == DATA_LAST
                      && !op_rd_q && match_q;
   assign rd_snap = rise && state_q == S_TA && cnt_q == 5'h00
                    && op_rd_q && match_q;
   assign rd_clr = rd_snap && reg_q == REG_STAT;
   assign link_now = link_ok_i & ~loop_q;
   assign link_up = link_now;

   assign ctrl_rd = {srst_q, loop_q, CTRL_SPD_AN, pwdn_q, iso_q,
                     CTRL_RSV_VAL};
   assign stat_rd = STAT_FIXED | {11'h000, st_fault_q, 1'b0, st_link_q,
                                  st_jabber_q, 1'b0};

   // Frame decoder, advances on each management clock rise
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         state_q <= S_IDLE;
         cnt_q <= 5'h00;
         ones_q <= 6'h00;
         pre_ok_q <= 1'b0;
         sh_q <= 12'h000;
         wsh_q <= 16'h0000;
         op_rd_q <= 1'b0;
         match_q <= 1'b0;
         reg_q <= 5'h00;
      end
      else if (rise)
      begin
         unique case (state_q)
            S_IDLE:
            begin
               if (bit_in)
               begin
                  if (ones_q != PRE_BITS)
                     ones_q <= ones_q + 6'h01;
                  if (ones_q == PRE_BITS - 6'h01)
                     pre_ok_q <= 1'b1;
               end
               else if (pre_ok_q)
               begin
                  state_q <= S_ST;
                  ones_q <= 6'h00;
               end
               else
                  ones_q <= 6'h00;
            end
            S_ST:
            begin
               // Start pattern is zero then one
               state_q <= bit_in ? S_HDR : S_IDLE;
               cnt_q <= 5'h00;
            end
            S_HDR:
            begin
               sh_q <= hdr_next;
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == HDR_LAST)
               begin
                  cnt_q <= 5'h00;
                  op_rd_q <= hdr_next[11:10] == OP_RD;
                  match_q <= hdr_next[9:5] == addr_q;
                  reg_q <= hdr_next[4:0];
                  // bad opcode demands a fresh preamble
                  if (hdr_next[11:10] != OP_RD && hdr_next[11:10] != OP_WR)
                  begin
                     pre_ok_q <= 1'b0;
                     state_q <= S_IDLE;
                  end
                  else
                     state_q <= S_TA;
               end
            end
            S_TA:
            begin
               sh_q <= hdr_next;
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q != 5'h00)
               begin
                  cnt_q <= 5'h00;
                  state_q <= S_DATA;
                  // bad write turnaround demands a fresh preamble
                  if (!op_rd_q && {sh_q[0], bit_in} != TA_WR)
                  begin
                     pre_ok_q <= 1'b0;
                     state_q <= S_IDLE;
                  end
               end
            end
            S_DATA:
            begin
               wsh_q <= wdata;
               cnt_q <= cnt_q + 5'h01;
               if (cnt_q == DATA_LAST)
               begin
                  state_q <= S_IDLE;
                  cnt_q <= 5'h00;
               end
            end
            default:
               state_q <= S_IDLE;
         endcase
      end
   end

   // Read driver: zero in second turnaround bit, then sixteen data bits
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         mdio_o <= 1'b1;
         mdio_oe <= 1'b0;
         rsh_q <= 16'h0000;
      end
      else if (rd_snap)
      begin
         // Snapshot keeps the value stable while latches clear
         rsh_q <= (reg_q == REG_CTRL) ? ctrl_rd :
                  (reg_q == REG_STAT) ? stat_rd : 16'h0000;
         mdio_o <= 1'b0;
         mdio_oe <= 1'b1;
      end
      else if (rise && mdio_oe &&
               (state_q == S_TA || (state_q == S_DATA && cnt_q != DATA_LAST)))
      begin
         mdio_o <= rsh_q[15];
         rsh_q <= {rsh_q[14:0], 1'b0};
      end
      else if (rise)
      begin
         mdio_o <= 1'b1;
         mdio_oe <= 1'b0;
      end
   end

   // Control register; registers stay writable in power down
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         srst_q <= 1'b0;
         loop_q <= 1'b0;
         pwdn_q <= 1'b0;
         iso_q <= 1'b0;
         srst_cnt_q <= 5'h00;
      end
      else
      begin
         if (srst_q)
         begin
            // hold bit while reset runs, then self clear
            srst_cnt_q <= srst_cnt_q + 5'h01;
            if (srst_cnt_q == 5'(SRST_CYC - 1))
               srst_q <= 1'b0;
            // loopback, power-down and isolate fields return to defaults
            loop_q <= 1'b0;
            pwdn_q <= 1'b0;
            iso_q <= 1'b0;
         end
         else if (wr_commit && reg_q == REG_CTRL)
         begin
            srst_q <= wdata[CTRL_SRST];
            srst_cnt_q <= 5'h00;
            loop_q <= wdata[CTRL_LOOP];
            pwdn_q <= wdata[CTRL_PWDN];
            iso_q <= wdata[CTRL_ISO];
         end
         // asserted pin sets the power-down bit
         if (pin_on)
            pwdn_q <= 1'b1;
      end
   end

   // PCS reset follows the self-clearing bit
   assign pcs_reset = srst_q;
   // power down is bit OR pin
   assign power_down = pwdn_q | pin_on;

   // Latched status; a new event wins over a read clear
   always_ff @(posedge core_clk)
   begin
      if (rst || srst_q)
      begin
         st_fault_q <= 1'b0;
         st_link_q <= 1'b0;
         st_jabber_q <= 1'b0;
      end
      else
      begin
         if (remote_fault_i)
            st_fault_q <= 1'b1;
         else if (rd_clr)
            st_fault_q <= 1'b0;
         if (jabber_i)
            st_jabber_q <= 1'b1;
         else if (rd_clr)
            st_jabber_q <= 1'b0;
         // link latches low, read reloads it
         // A loss in the read cycle still wins, so the next read sees it
         if (!link_now)
            st_link_q <= 1'b0;
         else if (rd_clr)
            st_link_q <= 1'b1;
      end
   end

   // MAC/PCS datapath, loopback and isolation
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         mii_rxd <= '0;
         mii_rx_dv <= 1'b0;
         mii_rxd_oe <= 1'b0;
         pcs_txd <= '0;
         pcs_tx_en <= 1'b0;
      end
      else
      begin
         mii_rxd_oe <= ~iso_q;
         pcs_txd <= iso_q ? '0 : mii_txd;
         pcs_tx_en <= mii_tx_en & ~iso_q & ~power_down;
         if (iso_q)
         begin
            mii_rxd <= '0;
            mii_rx_dv <= 1'b0;
         end
         else if (loop_q)
         begin
            mii_rxd <= mii_txd;
            mii_rx_dv <= mii_tx_en;
         end
         else
         begin
            mii_rxd <= pcs_rxd;
            mii_rx_dv <= pcs_rx_dv;
         end
      end
   end

   // Checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   srst_clear_a: assert property (
      $rose(srst_q) |-> srst_q[*8] ##[1:40] !srst_q)
      else $error("soft reset bit did not self clear in time");
   pcs_default_a: assert property (srst_q |=> !loop_q && !iso_q)
      else $error("PCS field survived soft reset");
   loop_route_a: assert property (
      loop_q && !iso_q |=> mii_rxd == $past(mii_txd))
      else $error("loopback data not returned");
   loop_link_a: assert property (loop_q |-> !link_up)
      else $error("link shown during loopback");
   fixed_ctrl_a: assert property (
      ctrl_rd[13:12] == CTRL_SPD_AN && ctrl_rd[9:0] == CTRL_RSV_VAL)
      else $error("fixed control field changed");
   pwdn_pin_a: assert property (pin_on |-> power_down ##1 pwdn_q)
      else $error("pin did not force power down");
   // Power down must also stop transmit towards the PCS
   pwdn_bit_a: assert property (pwdn_q |-> power_down ##1 !pcs_tx_en)
      else $error("power down bit ignored");
   isolate_mac_a: assert property (iso_q |=> !mii_rxd_oe && !mii_rx_dv)
      else $error("MAC side not isolated");
   preamble_ok_a: assert property (
      rise && state_q == S_IDLE && bit_in && ones_q == PRE_BITS - 6'h01
      |=> pre_ok_q)
      else $error("preamble count not honoured");
   fault_latch_a: assert property (
      remote_fault_i && !srst_q |=> st_fault_q)
      else $error("remote fault not latched");
   link_low_a: assert property (!link_now && !srst_q |=> !st_link_q)
      else $error("link loss not latched low");
   jabber_latch_a: assert property (
      jabber_i && !srst_q |=> st_jabber_q)
      else $error("jabber not latched");

   read_cov_c: cover property (rd_snap && reg_q == REG_STAT);
   write_cov_c: cover property (wr_commit && wdata[CTRL_SRST]);
   loop_cov_c: cover property (loop_q && mii_tx_en);
endmodule

// *** pbm_regs_tb_top.sv ***
// Testbench for the basic mode register pair behind its management pins.
// Assumes MAC and PCS signals on core_clk; strap address fixed at 5.
`timescale 1ns/100ps
module pbm_regs_tb_top;
   import pbm_pkg::*;
   // Address the strap gives the device
   localparam logic [4:0] ADDR = 5'h05;
   // Stimulus, all set at time zero
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic pin_n = 1'b1;
   logic link_ok = 1'b0;
   logic fault = 1'b0;
   logic jab = 1'b0;
   logic [3:0] txd = 4'h0;
   logic tx_en = 1'b0;
   logic [3:0] prxd = 4'h5;
   logic prx_dv = 1'b1;
   // Observed outputs
   logic mdc, mdio_i, mdio_o, mdio_oe;
   logic [3:0] rxd, pcs_txd;
   logic rx_dv, rxd_oe, pcs_tx_en, pcs_reset, power_down, link_up;
   logic [15:0] v;
   // Counters for the report and the hang guard
   int bad_count = 0;
   int check_count = 0;
   int cyc = 0;
   // 25 MHz core clock
   always #20 core_clk = ~core_clk;
   pbm_regs i_dut (.core_clk(core_clk), .rst(rst), .mdc(mdc),
      .mdio_i(mdio_i), .mdio_o(mdio_o), .mdio_oe(mdio_oe),
      .phy_addr_strap(4'h5), .irq_powerdown_pin_n(pin_n),
      .link_ok_i(link_ok), .remote_fault_i(fault), .jabber_i(jab),
      .mii_txd(txd), .mii_tx_en(tx_en), .mii_rxd(rxd), .mii_rx_dv(rx_dv),
      .mii_rxd_oe(rxd_oe), .pcs_txd(pcs_txd), .pcs_tx_en(pcs_tx_en),
      .pcs_rxd(prxd), .pcs_rx_dv(prx_dv), .pcs_reset(pcs_reset),
      .power_down(power_down), .link_up(link_up));
   pbm_smi_host i_host (.mdc(mdc), .mdio_line(mdio_i), .mdio_o(mdio_o),
      .mdio_oe(mdio_oe));
   // Word compare
   task automatic chk16(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %0t word %h expected %h", $time, g, e);
      end
   endtask
   // Pin compare
   task automatic chk1(input logic g, input logic e);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("FAIL %0t pin %b expected %b", $time, g, e);
      end
   endtask
   // Frames start on a falling core edge
   task automatic frm(input logic pre, input logic [1:0] op,
      input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd);
      @(negedge core_clk);
      i_host.xfer(pre, op, pa, ra, wd, v);
   endtask
   // Preamble-free read with its comparison
   task automatic rd(input logic [4:0] ra, input logic [15:0] e);
      frm(1'b0, OP_RD, ADDR, ra, 16'h0000);
      chk16(v, e);
   endtask
   task automatic wr(input logic [4:0] ra, input logic [15:0] d);
      frm(1'b0, OP_WR, ADDR, ra, d);
   endtask
   // Reset values; first frame carries the preamble
   task automatic t_reset_vals;
      frm(1'b1, OP_RD, ADDR, REG_CTRL, 16'h0000);
      chk16(v, 16'h2100);
      rd(REG_STAT, 16'h0061);
      chk1(power_down, 1'b0);
   endtask
   // Fixed fields ignore writes; power down and isolate take effect
   task automatic t_ctrl;
      link_ok = 1'b1;
      txd = 4'hA;
      tx_en = 1'b1;
      wr(REG_CTRL, 16'h5CFF);
      rd(REG_CTRL, 16'h6D00);
      chk1(power_down, 1'b1);
      chk1(pcs_tx_en, 1'b0);
      chk1(rxd_oe, 1'b0);
      chk1(rx_dv, 1'b0);
      chk16({12'h000, pcs_txd}, 16'h0000);
      chk1(link_up, 1'b0);
      wr(REG_CTRL, 16'h0000);
      chk1(power_down, 1'b0);
      chk1(pcs_tx_en, 1'b1);
      chk1(rxd_oe, 1'b1);
      chk16({12'h000, pcs_txd}, 16'h000A);
      chk1(link_up, 1'b1);
   endtask
   // Loopback: transmit nibble must come back on receive, not PCS data
   task automatic t_loop;
      wr(REG_CTRL, 16'h4000);
      txd = 4'hA;
      tx_en = 1'b1;
      repeat (2) @(negedge core_clk);
      chk16({12'h000, rxd}, 16'h000A);
      chk1(rx_dv, 1'b1);
      chk1(link_up, 1'b0);
      wr(REG_CTRL, 16'h0000);
      repeat (2) @(negedge core_clk);
      chk16({12'h000, rxd}, 16'h0005);
      tx_en = 1'b0;
   endtask
   // Soft reset clears loopback and status latches, self clears,
   // keeps the strap address
   task automatic t_srst;
      int n;
      n = 0;
      fault = 1'b1;
      @(negedge core_clk);
      fault = 1'b0;
      wr(REG_CTRL, 16'hC000);
      while (pcs_reset !== 1'b1 && n < 8)
      begin
         @(negedge core_clk);
         n++;
      end
      chk1(pcs_reset, 1'b1);
      repeat (24) @(negedge core_clk);
      chk1(pcs_reset, 1'b0);
      rd(REG_CTRL, 16'h2100);
      rd(REG_STAT, 16'h0061);
   endtask
   // Pin forces power down and sets the control bit
   task automatic t_pin;
      pin_n = 1'b0;
      repeat (4) @(negedge core_clk);
      chk1(power_down, 1'b1);
      rd(REG_CTRL, 16'h2900);
      pin_n = 1'b1;
      wr(REG_CTRL, 16'h0000);
      rd(REG_CTRL, 16'h2100);
      chk1(power_down, 1'b0);
   endtask
   // Latched status bits hold one read, then follow the live inputs
   task automatic t_latch;
      frm(1'b0, OP_RD, ADDR, REG_STAT, 16'h0000);
      rd(REG_STAT, 16'h0065);
      @(negedge core_clk);
      fault = 1'b1;
      jab = 1'b1;
      link_ok = 1'b0;
      @(negedge core_clk);
      fault = 1'b0;
      jab = 1'b0;
      link_ok = 1'b1;
      rd(REG_STAT, 16'h0073);
      rd(REG_STAT, 16'h0065);
   endtask
   // Frames to another address change nothing and get no answer,
   // and the decoder stays in step without a new preamble
   task automatic t_other;
      frm(1'b0, OP_WR, 5'h06, REG_CTRL, 16'h4000);
      frm(1'b0, OP_RD, 5'h06, REG_CTRL, 16'h0000);
      chk16(v, 16'hFFFF);
      rd(REG_CTRL, 16'h2100);
   endtask
   // Bad opcode drops sync; a fresh preamble restores it
   task automatic t_resync;
      frm(1'b0, 2'h0, ADDR, REG_CTRL, 16'h0000);
      rd(REG_CTRL, 16'hFFFF);
      frm(1'b1, OP_RD, ADDR, REG_CTRL, 16'h0000);
      chk16(v, 16'h2100);
   endtask
   // Report and verdict
   task automatic conclude;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Hang guard, well above the twenty-three frames of the run
   always @(posedge core_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         bad_count++;
         $display("FAIL %0t run did not finish", $time);
         conclude;
      end
   end
   // Main sequence
   initial
   begin
      repeat (3) @(negedge core_clk);
      rst = 1'b0;
      repeat (3) @(negedge core_clk);
      t_reset_vals;
      t_ctrl;
      t_loop;
      t_srst;
      t_pin;
      t_latch;
      t_other;
      t_resync;
      conclude;
   end
endmodule

// *** pbm_smi_host.sv ***
// Station management host model: serial frames on mdc and mdio.
// Assumes the device drives mdio_o while mdio_oe is high.
`timescale 1ns/100ps
module pbm_smi_host
(
   // Management pins
   output logic mdc,
   output logic mdio_line,
   // Device side of the data pin
   input wire logic mdio_o,
   input wire logic mdio_oe
);
   // Host drive value and its enable
   logic host_d = 1'b1;
   logic host_oe = 1'b0;
   // Pull-up on the line, so a released pin reads one, never a stale bit
   assign mdio_line = mdio_oe ? mdio_o : (host_oe ? host_d : 1'b1);
   // Clock rests low between frames, as a real host leaves it
   initial mdc = 1'b0;
   // One frame of 320 ns bits; data changes at mdc fall, read at rise
   task automatic xfer(input logic pre, input logic [1:0] op,
      input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] wd,
      output logic [15:0] rd);
      logic [63:0] bits;
      int i;
      bits = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
      rd = 16'h0000;
      for (i = pre ? 0 : 32; i < 64; i++)
      begin
         // Release the pin from the turnaround of a read
         host_oe = !(op == 2'h2 && i >= 46);
         host_d = bits[63-i];
         #160 mdc = 1'b1;
         if (i >= 48)
            rd[63-i] = mdio_line;
         #160 mdc = 1'b0;
      end
      host_oe = 1'b0;
   endtask
endmodule
